// [inc/avps_defines.svh]
`ifndef AVPS_DEFINES_SVH
`define AVPS_DEFINES_SVH
// ==========================================================
// Command header
`define AVPS_CMD_TYPE 3'h3
`define AVPS_PIPE 2'h2
`define AVPS_OPCODE 3'h4
`define AVPS_SUBOP 8'h00
`define AVPS_DW_LEN 16'h0004
// ==========================================================
// Dword slots within the command
`define AVPS_DW_HDR 3'h0
`define AVPS_DW_AREA 3'h1
`define AVPS_DW_DIM 3'h2
`define AVPS_DW_PIC 3'h3
`define AVPS_DW_RES 3'h4
`define AVPS_DW_ITH 3'h5
`define AVPS_DW_PAD6 3'h6
`define AVPS_DW_PAD7 3'h7
`define AVPS_DW_LAST 3'h7
// ==========================================================
// Field positions (command dwords and register images alike)
`define AVPS_F_TYPE 31:29
`define AVPS_F_LEN 15:0
`define AVPS_F_AREA 14:0
`define AVPS_F_AREA_PAD 31:15
`define AVPS_F_ROWS 23:16
`define AVPS_F_COLS 7:0
`define AVPS_F_CR 28:24
`define AVPS_F_CB 20:16
`define AVPS_F_SCAN 15:13
`define AVPS_F_MONO 12
`define AVPS_F_SMG 10
`define AVPS_F_STRUCT 9:8
`define AVPS_F_FS 7:0
`define AVPS_F_RES 31:24
`define AVPS_F_RES_LOW 26:24
`define AVPS_F_OVR 17
`define AVPS_F_SYNC 16
`define AVPS_F_MISC 12:0
// ==========================================================
// Limits
`define AVPS_AREA_MAX 16'h7FFF
`define AVPS_QP_MAX 5'h0C
`define AVPS_QP_MIN 5'h14
`define AVPS_STRUCT_BAD 2'h2
`define AVPS_FS_MAX 8'h10
`define AVPS_MISC_MASK 13'h1DFF
// ==========================================================
// Register map
`define AVPS_R_CTRL 8'h00
`define AVPS_R_STAT 8'h04
`define AVPS_R_DIM 8'h08
`define AVPS_R_PIC 8'h0C
`define AVPS_R_RES 8'h10
`define AVPS_R_HDR 8'h14
`define AVPS_C_START 0
`define AVPS_ST_BUSY 0
`define AVPS_ST_DONE 1
`define AVPS_ST_ERR 2
`define AVPS_ST_QM 3
`define AVPS_ST_SLICE 4
`define AVPS_DIM_MASK 32'h00FF00FF
`define AVPS_PIC_MASK 32'h1F1FE7FF
`define AVPS_RES_MASK 32'hFF031DFF
`define AVPS_DIM_RST 32'h00000000
`define AVPS_PIC_RST 32'h00000010
`define AVPS_RES_RST 32'h00000000
`define AVPS_HDR_RST 32'h00000000
`define AVPS_ADDR_W_MIN 5
`endif

// [inc/avps_pkg.sv]
`include "avps_defines.svh"
package avps_pkg;
  typedef struct packed {
    logic last;
    logic [31:0] dw;
  } avps_beat_t;

  typedef struct packed {
    logic [7:0] cols;
    logic [7:0] rows;
    logic [4:0] cr;
    logic [4:0] cb;
    logic [2:0] scan;
    logic smg;
    logic [1:0] pstruct;
    logic [7:0] fs;
    logic [7:0] res_off;
    logic sync_ovr;
    logic sync;
    logic [12:0] misc;
    logic [31:0] it_hdr;
  } avps_params_t;

  typedef enum {AVPS_IDLE, AVPS_CHECK, AVPS_SEND} avps_state_t;

  function automatic logic [15:0] avps_area(input logic [7:0] c, input logic [7:0] r);
    avps_area = {8'h00, c} * {8'h00, r};
  endfunction : avps_area

  function automatic logic avps_qp_ok(input logic [4:0] q);
    avps_qp_ok = ($signed(q) <= $signed(`AVPS_QP_MAX)) &&
                 ($signed(q) >= $signed(`AVPS_QP_MIN));
  endfunction : avps_qp_ok
endpackage : avps_pkg

// [design/avps_sticky.sv]
`timescale 1ns/1ns
module avps_sticky (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control
  input wire logic set,
  input wire logic clr,
  output logic q
);
  // A set in the clearing cycle is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end
endmodule : avps_sticky

// [design/avps_cmd_fmt.sv]
`timescale 1ns/1ns
`include "avps_defines.svh"
module avps_cmd_fmt (
  // Parameter snapshot and slot
  input avps_pkg::avps_params_t prm,
  input wire logic [2:0] idx,
  // Formatted beat and legality
  output avps_pkg::avps_beat_t beat,
  output logic bad
);
  import avps_pkg::*;

  logic [15:0] area;

  assign area = avps_area(prm.cols, prm.rows); // RULE6

  always_comb begin
    beat.last = (idx == `AVPS_DW_LAST); // RULE2
    beat.dw = '0;
    unique case (idx)
      `AVPS_DW_HDR: begin
        beat.dw = {`AVPS_CMD_TYPE, `AVPS_PIPE, `AVPS_OPCODE, `AVPS_SUBOP, `AVPS_DW_LEN}; // RULE1
      end
      `AVPS_DW_AREA: begin
        beat.dw[`AVPS_F_AREA] = area[`AVPS_F_AREA]; // RULE5
      end
      `AVPS_DW_DIM: begin
        beat.dw[`AVPS_F_ROWS] = prm.rows; // RULE7
        beat.dw[`AVPS_F_COLS] = prm.cols; // RULE8
      end
      `AVPS_DW_PIC: begin
        beat.dw[`AVPS_F_CR] = prm.cr; // RULE9
        beat.dw[`AVPS_F_CB] = prm.cb; // RULE10
        beat.dw[`AVPS_F_SCAN] = prm.scan;
        beat.dw[`AVPS_F_MONO] = 1'b1; // RULE12
        beat.dw[`AVPS_F_SMG] = prm.smg;
        beat.dw[`AVPS_F_STRUCT] = prm.pstruct;
        beat.dw[`AVPS_F_FS] = prm.fs;
      end
      `AVPS_DW_RES: begin
        beat.dw[`AVPS_F_RES] = prm.res_off;
        beat.dw[`AVPS_F_OVR] = prm.sync_ovr;
        beat.dw[`AVPS_F_SYNC] = prm.sync;
        beat.dw[`AVPS_F_MISC] = prm.misc & `AVPS_MISC_MASK;
      end
      `AVPS_DW_ITH: begin
        beat.dw = prm.it_hdr;
      end
      `AVPS_DW_PAD6, `AVPS_DW_PAD7: begin
        beat.dw = '0;
      end
    endcase
  end

  // Illegal settings are refused before any dword leaves
  assign bad = (area > `AVPS_AREA_MAX) || // RULE6
               (prm.rows == '0) || (prm.cols == '0) || // RULE7 RULE8
               !avps_qp_ok(prm.cr) || !avps_qp_ok(prm.cb) || // RULE9 RULE10
               (prm.pstruct == `AVPS_STRUCT_BAD) || // RULE15
               (prm.fs > `AVPS_FS_MAX) || // RULE16
               (prm.res_off[2:0] != 3'h0); // RULE21
endmodule : avps_cmd_fmt

// [design/avps_host.sv]
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "avps_defines.svh"
// ==========================================================
// Overview of operation
// RULE1 - First dword: type 3h, pipeline 2h, opcode 4h, sub-opcode 0h.
// RULE2 - Command is eight dwords; length field reads 0004h.
// RULE3 - Decoder holds parameters until reset or the next picture command.
// RULE4 - Picture command goes first each picture, before slice data.
// RULE5 - Area sits in dword 1 bits 14:0; bit 15 stays zero.
// RULE6 - Area equals width times height and fits fifteen bits.
// RULE7 - Height in dword 2 bits 23:16, from 1 to 255.
// RULE8 - Width in dword 2 bits 7:0, from 1 to 255.
// RULE9 - Cr offset in dword 3 bits 28:24, kept within -12..+12.
// RULE10 - Cb offset in dword 3 bits 20:16, same range.
// RULE11 - Bits 15..13 pick raster or special scan for three writes.
// RULE12 - Bit 12 of dword 3 is always written as one.
// RULE13 - Without scaling matrices the decoder uses flat built-in ones.
// RULE14 - With scaling matrices, a scaling matrix command must follow.
// RULE15 - Structure 00 frame, 01 top, 11 bottom; 10 never sent.
// RULE16 - Frame-store index 0..16, upper three bits zero.
// RULE17 - Index 0..15 selects motion write base from read bases.
// RULE18 - Index 16 uses top or bottom motion store base.
// RULE19 - Index normally 16.
// RULE20 - Decoder looks up order count by frame-store index.
// RULE21 - Residual offset in dword 4 bits 31:24, multiple of eight.
// RULE22 - Override set: sync flag only for intra blocks with neighbours.
// RULE23 - Override clear: command sync bit copied to every block.
// RULE24 - Dwords move one per cycle under valid/ready; update after all.
module avps_host #(
  parameter int ADDR_W = 8
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Command dword stream
  output logic cmd_valid,
  input wire logic cmd_ready,
  output avps_pkg::avps_beat_t cmd_beat,
  // Picture sequencing
  input wire logic qm_sent,
  output logic slice_data_ok,
  output logic matrix_cmd_due
);
  import avps_pkg::*;

  generate
    if (ADDR_W < `AVPS_ADDR_W_MIN) begin : g_bad_addr_w
      $error("ADDR_W too narrow for the register map");
    end
  endgenerate

  // ==========================================================
  // Register file
  logic [31:0] dim_q;
  logic [31:0] pic_q;
  logic [31:0] res_q;
  logic [31:0] hdr_q;
  logic [31:0] rd_d;
  logic [31:0] stat;
  logic hit_d;
  logic hit_q;
  logic setup;
  logic wr;
  logic start;
  logic take;
  logic busy;
  logic done_q;
  logic err_q;
  avps_params_t live;

  assign setup = psel && !penable;
  assign wr = psel && penable && pwrite && hit_q;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit_q;

  always_comb begin
    stat = '0;
    stat[`AVPS_ST_BUSY] = busy;
    stat[`AVPS_ST_DONE] = done_q;
    stat[`AVPS_ST_ERR] = err_q;
    stat[`AVPS_ST_QM] = matrix_cmd_due;
    stat[`AVPS_ST_SLICE] = slice_data_ok;
  end

  always_comb begin
    rd_d = '0;
    hit_d = 1'b1;
    unique case (paddr)
      ADDR_W'(`AVPS_R_CTRL): rd_d = '0;
      ADDR_W'(`AVPS_R_STAT): rd_d = stat;
      ADDR_W'(`AVPS_R_DIM): rd_d = dim_q;
      ADDR_W'(`AVPS_R_PIC): rd_d = pic_q;
      ADDR_W'(`AVPS_R_RES): rd_d = res_q;
      ADDR_W'(`AVPS_R_HDR): rd_d = hdr_q;
      default: hit_d = 1'b0;
    endcase
  end

  // Read data is taken in the setup cycle so prdata comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      hit_q <= 1'b0;
    end else if (setup) begin
      prdata <= rd_d;
      hit_q <= hit_d;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dim_q <= `AVPS_DIM_RST;
      pic_q <= `AVPS_PIC_RST; // RULE19
      res_q <= `AVPS_RES_RST;
      hdr_q <= `AVPS_HDR_RST;
    end else if (wr) begin
      unique case (paddr)
        ADDR_W'(`AVPS_R_DIM): dim_q <= pwdata & `AVPS_DIM_MASK;
        ADDR_W'(`AVPS_R_PIC): pic_q <= pwdata & `AVPS_PIC_MASK;
        ADDR_W'(`AVPS_R_RES): res_q <= pwdata & `AVPS_RES_MASK;
        ADDR_W'(`AVPS_R_HDR): hdr_q <= pwdata;
        default: ;
      endcase
    end
  end

  assign start = wr && (paddr == ADDR_W'(`AVPS_R_CTRL)) && pwdata[`AVPS_C_START];

  always_comb begin
    live.cols = dim_q[`AVPS_F_COLS];
    live.rows = dim_q[`AVPS_F_ROWS];
    live.cr = pic_q[`AVPS_F_CR];
    live.cb = pic_q[`AVPS_F_CB];
    live.scan = pic_q[`AVPS_F_SCAN];
    live.smg = pic_q[`AVPS_F_SMG];
    live.pstruct = pic_q[`AVPS_F_STRUCT];
    live.fs = pic_q[`AVPS_F_FS];
    live.res_off = res_q[`AVPS_F_RES];
    live.sync_ovr = res_q[`AVPS_F_OVR];
    live.sync = res_q[`AVPS_F_SYNC];
    live.misc = res_q[`AVPS_F_MISC];
    live.it_hdr = hdr_q;
  end

  // ==========================================================
  // Command sequencer
  avps_state_t state_q;
  avps_params_t snap_q;
  avps_beat_t fmt_beat;
  logic [2:0] cnt_q;
  logic [2:0] idx;
  logic bad;
  logic accept;
  logic fin;

  assign busy = (state_q != AVPS_IDLE);
  // A start while busy is ignored
  assign take = start && !busy;
  assign accept = cmd_valid && cmd_ready;
  assign fin = accept && cmd_beat.last;
  assign idx = (state_q == AVPS_CHECK) ? `AVPS_DW_HDR : cnt_q + 3'h1;

  avps_cmd_fmt u_fmt (
    .prm(snap_q),
    .idx(idx),
    .beat(fmt_beat),
    .bad(bad)
  );

  // Snapshot keeps the command coherent if software rewrites mid-send
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snap_q <= '0;
    end else if (take) begin
      snap_q <= live;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= AVPS_IDLE;
    end else begin
      unique case (state_q)
        AVPS_IDLE: if (take) state_q <= AVPS_CHECK;
        AVPS_CHECK: state_q <= bad ? AVPS_IDLE : AVPS_SEND;
        AVPS_SEND: if (fin) state_q <= AVPS_IDLE; // RULE2
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q == AVPS_CHECK) begin
      cnt_q <= `AVPS_DW_HDR;
    end else if (accept) begin
      cnt_q <= idx;
    end
  end

  // One dword per handshake, held while the decoder stalls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_valid <= 1'b0;
      cmd_beat <= '0;
    end else if (state_q == AVPS_CHECK && !bad) begin
      cmd_valid <= 1'b1;
      cmd_beat <= fmt_beat; // RULE1
    end else if (fin) begin
      cmd_valid <= 1'b0; // RULE24
    end else if (accept) begin
      cmd_beat <= fmt_beat; // RULE24
    end
  end

  // ==========================================================
  // Status flags
  avps_sticky u_done (
    .pclk(pclk),
    .presetn(presetn),
    .set(fin),
    .clr(take),
    .q(done_q)
  );

  avps_sticky u_err (
    .pclk(pclk),
    .presetn(presetn),
    .set(state_q == AVPS_CHECK && bad),
    .clr(take),
    .q(err_q)
  );

  // Slice data may flow only once this picture's command is out
  avps_sticky u_slice (
    .pclk(pclk),
    .presetn(presetn),
    .set(fin), // RULE4
    .clr(take),
    .q(slice_data_ok)
  );

  avps_sticky u_qm (
    .pclk(pclk),
    .presetn(presetn),
    .set(fin && snap_q.smg), // RULE14
    .clr(qm_sent),
    .q(matrix_cmd_due)
  );

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  logic [3:0] hb_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hb_q <= '0;
    end else if (state_q == AVPS_CHECK) begin
      hb_q <= '0;
    end else if (accept) begin
      hb_q <= hb_q + 4'h1;
    end
  end

  sequence s_go;
    state_q == AVPS_CHECK && !bad;
  endsequence

  sequence s_hdr_out;
    cmd_valid && cmd_beat.dw[`AVPS_F_TYPE] == `AVPS_CMD_TYPE &&
      cmd_beat.dw[28:16] == {`AVPS_PIPE, `AVPS_OPCODE, `AVPS_SUBOP};
  endsequence

  sequence s_slot(logic [2:0] k);
    cmd_valid && cnt_q == k;
  endsequence

  hdr_launch_a: assert property (s_go |=> s_hdr_out) // RULE1
    else $error("header dword not launched after check");

  len_field_a: assert property (s_slot(`AVPS_DW_HDR) |->
    cmd_beat.dw[`AVPS_F_LEN] == `AVPS_DW_LEN) // RULE2
    else $error("length field wrong");

  burst_len_a: assert property (fin |-> hb_q == 4'h7) // RULE2
    else $error("command did not carry eight dwords");

  stall_hold_a: assert property (cmd_valid && !cmd_ready |=>
    cmd_valid && $stable(cmd_beat)) // RULE24
    else $error("dword changed while stalled");

  area_word_a: assert property (s_slot(`AVPS_DW_AREA) |->
    cmd_beat.dw[`AVPS_F_AREA_PAD] == '0 &&
    cmd_beat.dw[`AVPS_F_AREA] == 15'(avps_area(snap_q.cols, snap_q.rows))) // RULE5 RULE6
    else $error("area dword wrong");

  dim_range_a: assert property (s_slot(`AVPS_DW_DIM) |->
    cmd_beat.dw[`AVPS_F_ROWS] != '0 && cmd_beat.dw[`AVPS_F_COLS] != '0) // RULE7 RULE8
    else $error("zero frame dimension sent");

  qp_range_a: assert property (s_slot(`AVPS_DW_PIC) |->
    avps_qp_ok(cmd_beat.dw[`AVPS_F_CR]) && avps_qp_ok(cmd_beat.dw[`AVPS_F_CB])) // RULE9 RULE10
    else $error("chroma offset out of range");

  mono_bit_a: assert property (s_slot(`AVPS_DW_PIC) |->
    cmd_beat.dw[`AVPS_F_MONO]) // RULE12
    else $error("monochrome mode bit not set");

  pic_struct_a: assert property (s_slot(`AVPS_DW_PIC) |->
    cmd_beat.dw[`AVPS_F_STRUCT] != `AVPS_STRUCT_BAD) // RULE15
    else $error("invalid picture structure sent");

  fs_index_a: assert property (s_slot(`AVPS_DW_PIC) |->
    cmd_beat.dw[`AVPS_F_FS] <= `AVPS_FS_MAX) // RULE16
    else $error("frame-store index above limit");

  res_align_a: assert property (s_slot(`AVPS_DW_RES) |->
    cmd_beat.dw[`AVPS_F_RES_LOW] == 3'h0) // RULE21
    else $error("residual offset not aligned");

  // A fresh start may legally clear the error one cycle after the refusal
  refuse_bad_a: assert property (state_q == AVPS_CHECK && bad |=>
    (!cmd_valid && err_q) ##1 (!cmd_valid && (err_q || $past(take)))) // RULE6
    else $error("illegal settings were not refused");

  slice_gate_a: assert property ($rose(slice_data_ok) |-> $past(fin)) // RULE4
    else $error("slice data enabled before picture command");

  matrix_due_a: assert property (fin && snap_q.smg |=> matrix_cmd_due) // RULE14
    else $error("scaling matrix command not requested");
endmodule : avps_host

// [bench/avps_dec_model.sv]
`timescale 1ns/1ns
// ==========================================================
// Decoder end of the command stream
module avps_dec_model
  import avps_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Stall control from the bench
  input wire logic slow,
  // Command stream
  input wire logic cmd_valid,
  input avps_pkg::avps_beat_t cmd_beat,
  output logic cmd_ready,
  // Held picture state
  output logic [7:0][31:0] held,
  output logic [7:0] n_cmd,
  output logic fmt_err,
  output logic [1:0] mv_sel,
  output logic flat_qm,
  output logic [4:0] poc_idx,
  output logic [1:0] sync_mode
);
  logic [6:0][31:0] buf_q;
  logic [2:0] idx_q;
  logic take;
  assign take = cmd_valid && cmd_ready;
  // Slow mode drops ready every other cycle to stretch each dword
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cmd_ready <= 1'b0;
    else cmd_ready <= slow ? ~cmd_ready : 1'b1;
  end
  // Held set changes only on the eighth dword, cleared only by reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_q <= '0;
      idx_q <= 3'h0;
      held <= '0;
      n_cmd <= 8'h00;
      fmt_err <= 1'b0;
    end else if (take) begin
      idx_q <= idx_q + 3'h1;
      if (idx_q != 3'h7) buf_q[idx_q] <= cmd_beat.dw;
      if (cmd_beat.last != (idx_q == 3'h7)) fmt_err <= 1'b1;
      if (idx_q == 3'h0 && cmd_beat.dw != 32'h74000004) fmt_err <= 1'b1;
      if (idx_q == 3'h7) begin
        held <= {cmd_beat.dw, buf_q};
        n_cmd <= n_cmd + 8'h01;
      end
    end
  end
  // Motion store base: 0 read-base set, 1 top store, 2 bottom store
  always_comb begin
    if (held[3][4:0] < 5'h10) mv_sel = 2'h0;
    else mv_sel = (held[3][9:8] == 2'b11) ? 2'h2 : 2'h1;
  end
  // Built-in flat matrices unless the picture announces its own
  assign flat_qm = !held[3][10];
  // Order count of the current picture is looked up by its frame-store index
  assign poc_idx = held[3][4:0];
  // Sync handling: 2 intra-only override, otherwise a copy of the command bit
  assign sync_mode = held[4][17] ? 2'h2 : {1'b0, held[4][16]};
endmodule : avps_dec_model

// [bench/avps_host_tb.sv]
`timescale 1ns/1ns
module avps_host_tb;
  import avps_pkg::*;
  typedef struct packed {
    logic [31:0] dim;
    logic [31:0] pic;
    logic [31:0] res;
    logic [31:0] hdr;
    logic bad;
  } avps_row_t;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic cmd_valid, cmd_ready, qm_sent, slice_data_ok, matrix_cmd_due, slow, fmt_err, se;
  avps_beat_t cmd_beat;
  logic [7:0][31:0] held, exp_dw;
  logic [7:0] n_cmd, exp_n;
  logic [15:0] area;
  logic flat_qm;
  logic [1:0] mv_sel, sync_mode;
  logic [4:0] poc_idx;
  int err_count, check_count;
  avps_row_t rows [12];

  avps_host #(.ADDR_W(8)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_beat(cmd_beat), .qm_sent(qm_sent), .slice_data_ok(slice_data_ok),
    .matrix_cmd_due(matrix_cmd_due));
  avps_dec_model u_dec (.pclk(pclk), .presetn(presetn), .slow(slow), .cmd_valid(cmd_valid),
    .cmd_beat(cmd_beat), .cmd_ready(cmd_ready), .held(held), .n_cmd(n_cmd),
    .fmt_err(fmt_err), .mv_sel(mv_sel), .flat_qm(flat_qm), .poc_idx(poc_idx),
    .sync_mode(sync_mode));

  initial pclk = 1'b0;
  always #4 pclk = ~pclk;

  // ==========================================================
  // Shared tasks
  task summarize;
    $display("errors=%0d checks=%0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Polls status until done or error shows, at most 40 reads
  task wait_done;
    for (int i = 0; i < 40; i++) begin
      apb(1'b0, 8'h04, 32'h0);
      if (rd[2:1] != 2'b00) break;
    end
  endtask : wait_done

  initial begin
    repeat (20000) @(posedge pclk);
    err_count++;
    summarize();
  end

  // ==========================================================
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    qm_sent = 1'b0;
    slow = 1'b0;
    err_count = 0;
    check_count = 0;
    exp_dw = '0;
    exp_n = 8'h00;
    rows = '{'{32'h00440078, 32'h0C14E410, 32'h08030000, 32'hA5A50001, 1'b0},
             '{32'h00000010, 32'h00000010, 32'h0, 32'h0, 1'b1},
             '{32'h00FF0000, 32'h00000010, 32'h0, 32'h0, 1'b1},
             '{32'h00FF00FF, 32'h00000010, 32'h0, 32'h0, 1'b1},
             '{32'h00020002, 32'h00000210, 32'h0, 32'h0, 1'b1},
             '{32'h00020002, 32'h00000011, 32'h0, 32'h0, 1'b1},
             '{32'h00020002, 32'h00130010, 32'h0, 32'h0, 1'b1},
             '{32'h00020002, 32'h0D000010, 32'h0, 32'h0, 1'b1},
             '{32'h00020002, 32'h00000010, 32'h04000000, 32'h0, 1'b1},
             '{32'h008000FF, 32'h00000110, 32'h10001FFF, 32'h0, 1'b0},
             '{32'h00010001, 32'h00000305, 32'h00010000, 32'h12345678, 1'b0},
             '{32'h00020003, 32'h00000310, 32'h00020000, 32'h0, 1'b0}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h00000010);
    apb(1'b1, 8'h18, 32'hFFFFFFFF);
    chk(32'(se), 32'h1);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
      slow <= i[0];
      apb(1'b1, 8'h08, rows[i].dim);
      apb(1'b1, 8'h0C, rows[i].pic);
      apb(1'b1, 8'h10, rows[i].res);
      apb(1'b1, 8'h14, rows[i].hdr);
      apb(1'b1, 8'h00, 32'h1);
      wait_done();
      chk(rd, rows[i].bad ? 32'h4 : (32'h12 | {21'h0, rows[i].pic[10], 3'h0}));
      if (!rows[i].bad) begin
        area = {8'h00, rows[i].dim[7:0]} * {8'h00, rows[i].dim[23:16]};
        exp_dw = {32'h0, 32'h0, rows[i].hdr, rows[i].res & 32'hFF031DFF,
          (rows[i].pic & 32'h1F1FE7FF) | 32'h1000,
          {8'h00, rows[i].dim[23:16], 8'h00, rows[i].dim[7:0]}, {17'h0, area[14:0]},
          32'h74000004};
        exp_n = exp_n + 8'h01;
      end
      for (int k = 0; k < 8; k++) chk(held[k], exp_dw[k]);
      chk(32'(n_cmd), 32'(exp_n));
      chk(32'(fmt_err), 32'h0);
      chk(32'(slice_data_ok), 32'(!rows[i].bad));
      chk(32'(matrix_cmd_due), 32'(!rows[i].bad && rows[i].pic[10]));
      chk(32'(mv_sel), (exp_dw[3][4:0] < 5'h10) ? 32'h0 :
        ((exp_dw[3][9:8] == 2'b11) ? 32'h2 : 32'h1));
      chk(32'(flat_qm), 32'(!exp_dw[3][10]));
      chk(32'(poc_idx), 32'(exp_dw[3][4:0]));
      chk(32'(sync_mode), exp_dw[4][17] ? 32'h2 : 32'(exp_dw[4][16]));
      if (matrix_cmd_due === 1'b1) begin
        qm_sent <= 1'b1;
        @(posedge pclk);
        qm_sent <= 1'b0;
        @(posedge pclk);
        @(posedge pclk);
        chk(32'(matrix_cmd_due), 32'h0);
      end
    end
    // A second start while busy must not send a second command
    slow <= 1'b1;
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h00, 32'h1);
    wait_done();
    chk(32'(n_cmd), 32'(exp_n + 8'h01));
    // Reset in the middle of a command clears everything held
    apb(1'b1, 8'h00, 32'h1);
    repeat (4) @(posedge pclk);
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(32'(cmd_valid), 32'h0);
    presetn <= 1'b1;
    for (int k = 0; k < 8; k++) chk(held[k], 32'h0);
    chk(32'(slice_data_ok), 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h00000010);
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0);
    summarize();
  end
endmodule : avps_host_tb
